/* File: hw/hpb_pkg.sv */
// Package of constants for the host parallel bus pin block
package hpb_pkg;

	// ****************************************
	// Bus geometry
	// ****************************************
	localparam int HPB_DATA_W = 32;
	localparam int HPB_ADDR_W = 16;
	localparam int HPB_ADDR_LSB = 2;
	localparam int HPB_BIT2 = 2;
	localparam int HPB_BIT3 = 3;
	localparam int HPB_BIT4 = 4;
	localparam int HPB_BIT5 = 5;

	// ****************************************
	// Reset values and strap encodings
	// ****************************************
	localparam logic HPB_STRAP_NONMUX = 1'h0;
	localparam logic HPB_STRAP_MUX = 1'h1;
	localparam logic [31:0] HPB_DATA_RST = 32'h0000_0000;
	localparam logic [15:0] HPB_ADDR_RST = 16'h0000;
	localparam int HPB_SYNC_STAGES = 2;

	// ****************************************
	// Access state machine
	// ****************************************
	typedef enum logic [1:0] {
		HPB_IDLE = 2'h0,
		HPB_ADDR = 2'h1,
		HPB_DATA = 2'h3
	} hpb_state_t;

endpackage

/* File: hw/hpb_sync.sv */
// Two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/100ps
module hpb_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Pins in, synchronised out
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;

	// First stage only feeds second stage
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			meta_reg <= RST_VAL;
			sync_out <= RST_VAL;
		end else begin
			meta_reg <= pin_in;
			sync_out <= meta_reg;
		end
	end
endmodule

/* File: hw/hpb_port.sv */
// Host parallel bus pin block of the device: strobes, address capture, data lines
`timescale 1ns/100ps
module hpb_port
	import hpb_pkg::*;
#(
	parameter int DATA_W = HPB_DATA_W,
	parameter int ADDR_W = HPB_ADDR_W
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Host strobes (pins)
	input wire logic chip_sel_n,
	input wire logic out_en_n,
	input wire logic wr_en_n,
	input wire logic bus_mux_strap,
	// Dedicated address pins, bit 2 doubles as latch strobe
	input wire logic addr_bit2_or_strobe,
	input wire logic addr_bit4_line,
	input wire logic [ADDR_W-1:0] addr_hi_in,
	// Data pins, three signals each
	input wire logic [DATA_W-1:0] data_in,
	output logic [DATA_W-1:0] data_out,
	output logic [DATA_W-1:0] data_oe_n,
	// Internal user side
	input wire logic [DATA_W-1:0] rd_data,
	output logic [ADDR_W-1:0] acc_addr,
	output logic [DATA_W-1:0] wr_data,
	output logic wr_strobe,
	output logic rd_strobe,
	output logic mux_mode
);
	import hpb_pkg::*;

	// ****************************************
	// Synchronised pin inputs
	// ****************************************
	localparam int NCTL = 6;
	localparam int NS = NCTL + ADDR_W + DATA_W;
	localparam logic [NS-1:0] SYNC_RST = {4'hF, 2'h0, {(ADDR_W + DATA_W){1'b0}}};
	logic [NS-1:0] sync_vec;
	logic cs_s, oe_s, we_s, strap_s, ale_s, a4_s;
	logic [ADDR_W-1:0] ahi_s;
	logic [DATA_W-1:0] din_s;

	hpb_sync #(.WIDTH(NS), .RST_VAL(SYNC_RST)) u_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.pin_in({chip_sel_n, out_en_n, wr_en_n, addr_bit2_or_strobe, bus_mux_strap,
			addr_bit4_line, addr_hi_in, data_in}),
		.sync_out(sync_vec)
	);

	// Unpack synchronised vector
	assign {cs_s, oe_s, we_s, ale_s, strap_s, a4_s, ahi_s, din_s} = sync_vec;

	// ****************************************
	// Strap capture and edge history
	// ****************************************
	logic strap_reg;
	logic strap_taken_reg;
	logic [1:0] strap_wait_reg;
	logic cs_d_reg;
	logic ale_d_reg;
	logic cs_fall;
	logic ale_fall;

	// Strap latched once, after the synchroniser has flushed its reset value
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			strap_reg <= HPB_STRAP_NONMUX;
			strap_taken_reg <= 1'b0;
			strap_wait_reg <= 2'h0;
		end else if (!strap_taken_reg) begin
			if (strap_wait_reg == 2'(HPB_SYNC_STAGES)) begin
				strap_reg <= strap_s;
				strap_taken_reg <= 1'b1;
			end else begin
				strap_wait_reg <= strap_wait_reg + 2'h1;
			end
		end
	end

	// Previous levels for edge detection
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cs_d_reg <= 1'b1;
			ale_d_reg <= 1'b0;
		end else begin
			cs_d_reg <= cs_s;
			ale_d_reg <= ale_s;
		end
	end

	assign cs_fall = cs_d_reg && !cs_s;
	assign ale_fall = ale_d_reg && !ale_s && (strap_reg == HPB_STRAP_MUX);

	// ****************************************
	// Access state machine
	// ****************************************
	hpb_state_t state_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic is_write_reg;

	// Track address and data phases of an access
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_reg <= HPB_IDLE;
		end else begin
			case (state_reg)
				HPB_IDLE: begin
					if (strap_taken_reg && cs_fall) begin
						state_reg <= (strap_reg == HPB_STRAP_MUX) ? HPB_ADDR : HPB_DATA;
					end
				end
				HPB_ADDR: begin
					if (cs_s) begin
						state_reg <= HPB_IDLE;
					end else if (ale_fall) begin
						state_reg <= HPB_DATA;
					end
				end
				HPB_DATA: begin
					if (cs_s) begin
						state_reg <= HPB_IDLE;
					end
				end
				default: state_reg <= HPB_IDLE;
			endcase
		end
	end

	// Address capture per bus mode
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			addr_reg <= HPB_ADDR_RST;
		end else if (state_reg == HPB_IDLE && cs_fall && strap_taken_reg
			&& strap_reg == HPB_STRAP_NONMUX) begin
			// Dedicated lines, bits 2 and 4 taken from dedicated inputs too
			addr_reg <= ahi_s;
			addr_reg[HPB_BIT4 - HPB_ADDR_LSB] <= a4_s;
			addr_reg[HPB_BIT2 - HPB_ADDR_LSB] <= ale_s;
		end else if (state_reg == HPB_ADDR && ale_fall) begin
			// Address on shared data pins, dedicated bit 4 ignored
			addr_reg <= din_s[ADDR_W + HPB_ADDR_LSB - 1:HPB_ADDR_LSB];
		end
	end

	// Direction taken at start of data phase
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			is_write_reg <= 1'b0;
		end else if (state_reg != HPB_DATA) begin
			is_write_reg <= !we_s;
		end
	end

	// ****************************************
	// Data strobes and data lines
	// ****************************************
	logic enter_data;
	assign enter_data = (state_reg != HPB_DATA) && !cs_s && strap_taken_reg
		&& ((state_reg == HPB_IDLE && cs_fall && strap_reg == HPB_STRAP_NONMUX)
		|| (state_reg == HPB_ADDR && ale_fall));

	// One-cycle strobes at start of data phase
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wr_strobe <= 1'b0;
			rd_strobe <= 1'b0;
			wr_data <= HPB_DATA_RST;
			acc_addr <= HPB_ADDR_RST;
			mux_mode <= HPB_STRAP_NONMUX;
		end else begin
			wr_strobe <= enter_data && !we_s;
			rd_strobe <= enter_data && we_s;
			mux_mode <= strap_reg;
			if (state_reg == HPB_DATA && is_write_reg) begin
				wr_data <= din_s;
			end
			if (state_reg == HPB_DATA) begin
				acc_addr <= addr_reg;
			end
		end
	end

	// Drive data lines only while output enable is low in a read
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			data_out <= HPB_DATA_RST;
			data_oe_n <= {DATA_W{1'b1}};
		end else begin
			data_out <= rd_data;
			data_oe_n <= {DATA_W{!( !oe_s && we_s && state_reg == HPB_DATA)}};
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	property p_oe_gate;
		@(posedge ref_clk) disable iff (rst)
			oe_s |=> data_oe_n == {DATA_W{1'b1}};
	endproperty
	a_oe_gate: assert property (p_oe_gate) else $error("data driven with oe high");

	property p_no_drive_write;
		@(posedge ref_clk) disable iff (rst)
			!we_s |=> &data_oe_n;
	endproperty
	a_no_drive_write: assert property (p_no_drive_write) else $error("drive in write");

	property p_wr_strobe;
		@(posedge ref_clk) disable iff (rst)
			wr_strobe |-> !$past(we_s) && !rd_strobe;
	endproperty
	a_wr_strobe: assert property (p_wr_strobe) else $error("write strobe wrong");

	property p_a4_capture;
		@(posedge ref_clk) disable iff (rst)
			(state_reg == HPB_IDLE && cs_fall && strap_taken_reg && !strap_reg)
			|=> addr_reg[HPB_BIT4 - HPB_ADDR_LSB] == $past(a4_s);
	endproperty
	a_a4_capture: assert property (p_a4_capture) else $error("bit4 not captured");

	sequence s_mux_addr;
		state_reg == HPB_ADDR && ale_fall;
	endsequence
	property p_mux_addr;
		@(posedge ref_clk) disable iff (rst)
			s_mux_addr |=> addr_reg[1:0] == $past(din_s[3:2]) && state_reg != HPB_ADDR;
	endproperty
	a_mux_addr: assert property (p_mux_addr) else $error("mux address wrong");

	property p_a4_ignored;
		@(posedge ref_clk) disable iff (rst)
			(strap_reg && state_reg != HPB_ADDR) |=> $stable(addr_reg);
	endproperty
	a_a4_ignored: assert property (p_a4_ignored) else $error("addr moved in mux");

	property p_ale_phase;
		@(posedge ref_clk) disable iff (rst)
			(state_reg == HPB_ADDR && !cs_s && !ale_fall) |=> state_reg == HPB_ADDR;
	endproperty
	a_ale_phase: assert property (p_ale_phase) else $error("left address early");

	property p_nonmux_direct;
		@(posedge ref_clk) disable iff (rst)
			!strap_reg |-> state_reg != HPB_ADDR;
	endproperty
	a_nonmux_direct: assert property (p_nonmux_direct) else $error("addr phase nonmux");

	property p_wr_data;
		@(posedge ref_clk) disable iff (rst)
			(state_reg == HPB_DATA && is_write_reg) |=> wr_data == $past(din_s);
	endproperty
	a_wr_data: assert property (p_wr_data) else $error("write data lost");
endmodule

/* File: tb/hpb_host_model.sv */
// Host processor model that drives the parallel bus pins of the port
`timescale 1ns/100ps
module hpb_host_model
	import hpb_pkg::*;
(
	// Clock
	input wire logic ref_clk,
	// Strobes and address pins toward the device
	output logic chip_sel_n,
	output logic out_en_n,
	output logic wr_en_n,
	output logic addr_bit2_or_strobe,
	output logic addr_bit4_line,
	output logic [hpb_pkg::HPB_ADDR_W-1:0] addr_hi_in,
	// Resolved data wire and the device side of it
	output logic [hpb_pkg::HPB_DATA_W-1:0] data_in,
	input wire logic [hpb_pkg::HPB_DATA_W-1:0] data_out,
	input wire logic [hpb_pkg::HPB_DATA_W-1:0] data_oe_n
);
	import hpb_pkg::*;
	logic [HPB_DATA_W-1:0] host_d;
	logic host_drv;

	// Wire level: device where enabled, else host, else inverse of last host value
	assign data_in = (~data_oe_n & data_out) | (data_oe_n & (host_drv ? host_d : ~host_d));

	// Idle bus at time zero
	initial begin
		chip_sel_n = 1'h1;
		out_en_n = 1'h1;
		wr_en_n = 1'h1;
		addr_bit2_or_strobe = 1'h1;
		addr_bit4_line = 1'h0;
		addr_hi_in = 16'h0000;
		host_d = 32'h0000_0000;
		host_drv = 1'h0;
	end

	// One word access; dead pins carry the inverse to show they are ignored
	task automatic access(input logic mux, input logic wr, input logic [HPB_ADDR_W-1:0] addr,
		input logic [HPB_DATA_W-1:0] wdata, output logic [HPB_DATA_W-1:0] rdata,
		output logic drove);
		drove = 1'h0;
		// Direction settles while chip select is still high
		@(posedge ref_clk);
		wr_en_n <= ~wr;
		@(posedge ref_clk);
		chip_sel_n <= 1'h0;
		addr_bit2_or_strobe <= mux ? 1'h1 : addr[0];
		addr_bit4_line <= mux ? ~addr[2] : addr[2];
		// Non-mux vector bits 0 and 2 inverted, so the dedicated pins must win
		addr_hi_in <= mux ? ~addr : (addr ^ 16'h0005);
		host_d <= mux ? {14'h0000, addr, 2'h0} : wdata;
		host_drv <= mux | wr;
		out_en_n <= mux | wr;
		repeat (5) @(posedge ref_clk);
		// Strobe falls in mux; address pins move after capture otherwise
		addr_bit2_or_strobe <= mux ? 1'h0 : ~addr[0];
		addr_bit4_line <= ~addr[2];
		addr_hi_in <= ~addr;
		repeat (2) @(posedge ref_clk);
		host_d <= wdata;
		host_drv <= wr;
		// Output enable low in writes too: only the direction may hold the device off
		out_en_n <= 1'h0;
		repeat (10) begin
			@(posedge ref_clk);
			drove = drove | (data_oe_n !== 32'hFFFF_FFFF);
		end
		rdata = data_in;
		chip_sel_n <= 1'h1;
		out_en_n <= 1'h1;
		host_drv <= 1'h0;
		repeat (6) @(posedge ref_clk);
	endtask
endmodule

/* File: tb/hpb_port_tb_top.sv */
// Self-checking bench of the host parallel bus pin block
`timescale 1ns/100ps
module hpb_port_tb_top;
	import hpb_pkg::*;
	logic ref_clk, rst, bus_mux_strap, chip_sel_n, out_en_n, wr_en_n;
	logic addr_bit2_or_strobe, addr_bit4_line, wr_strobe, rd_strobe, mux_mode;
	logic [HPB_ADDR_W-1:0] addr_hi_in, acc_addr, last_addr;
	logic [HPB_DATA_W-1:0] data_in, data_out, data_oe_n, rd_data, wr_data, last_wdata;
	int errors = 0, checks = 0, wr_cnt = 0, rd_cnt = 0;

	// ****************************************
	// Clock, design and host
	// ****************************************
	initial begin
		ref_clk = 1'h0;
		forever #20 ref_clk = ~ref_clk;
	end

	hpb_port dut (.ref_clk(ref_clk), .rst(rst), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
		.wr_en_n(wr_en_n), .bus_mux_strap(bus_mux_strap),
		.addr_bit2_or_strobe(addr_bit2_or_strobe), .addr_bit4_line(addr_bit4_line),
		.addr_hi_in(addr_hi_in), .data_in(data_in), .data_out(data_out),
		.data_oe_n(data_oe_n), .rd_data(rd_data), .acc_addr(acc_addr), .wr_data(wr_data),
		.wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .mux_mode(mux_mode));

	hpb_host_model host (.ref_clk(ref_clk), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
		.wr_en_n(wr_en_n), .addr_bit2_or_strobe(addr_bit2_or_strobe),
		.addr_bit4_line(addr_bit4_line), .addr_hi_in(addr_hi_in), .data_in(data_in),
		.data_out(data_out), .data_oe_n(data_oe_n));

	// Strobe counts and last address and data seen while selected
	always @(posedge ref_clk) begin
		wr_cnt <= wr_cnt + int'(wr_strobe === 1'h1);
		rd_cnt <= rd_cnt + int'(rd_strobe === 1'h1);
		if (chip_sel_n === 1'h0) begin
			last_addr <= acc_addr;
			last_wdata <= wr_data;
		end
	end

	// ****************************************
	// Checking and scenarios
	// ****************************************
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic summarize();
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Reset with a strap value, then check idle outputs
	task automatic t_reset(input logic s);
		@(posedge ref_clk);
		bus_mux_strap <= s;
		rst <= 1'h1;
		repeat (4) @(posedge ref_clk);
		rst <= 1'h0;
		// Strap is taken on the third edge after release and shows one edge later
		repeat (5) @(posedge ref_clk);
		chk("mux_mode", {31'h0, s}, {31'h0, mux_mode});
		chk("data_oe_n", 32'hFFFF_FFFF, data_oe_n);
	endtask

	// Write: address and data land, one write pulse, lines never driven
	task automatic t_write(input logic mux, input logic [15:0] addr, input logic [31:0] wd);
		int w0, r0;
		logic [31:0] rd;
		logic dr;
		w0 = wr_cnt;
		r0 = rd_cnt;
		host.access(mux, 1'h1, addr, wd, rd, dr);
		chk("acc_addr", {16'h0, addr}, {16'h0, last_addr});
		chk("wr_data", wd, last_wdata);
		chk("wr_strobe count", 32'h1, wr_cnt - w0);
		chk("rd_strobe count", 32'h0, rd_cnt - r0);
		chk("drove on write", 32'h0, {31'h0, dr});
	endtask

	// Read: data returned on the pins, one read pulse, lines released after
	task automatic t_read(input logic mux, input logic [15:0] addr, input logic [31:0] rv);
		int w0, r0;
		logic [31:0] rd;
		logic dr;
		rd_data <= rv;
		w0 = wr_cnt;
		r0 = rd_cnt;
		// Host last value equals rv, so a released bus shows its inverse
		host.access(mux, 1'h0, addr, rv, rd, dr);
		chk("read data", rv, rd);
		chk("acc_addr", {16'h0, addr}, {16'h0, last_addr});
		chk("rd_strobe count", 32'h1, rd_cnt - r0);
		chk("wr_strobe count", 32'h0, wr_cnt - w0);
		chk("drove on read", 32'h1, {31'h0, dr});
		chk("data_oe_n idle", 32'hFFFF_FFFF, data_oe_n);
	endtask

	// Main sequence
	initial begin
		rst = 1'h1;
		bus_mux_strap = 1'h0;
		rd_data = 32'h0000_0000;
		t_reset(1'h0);
		t_write(1'h0, 16'hA50B, 32'h5A5A_5A04);
		t_read(1'h0, 16'h0F35, 32'hC3A5_96D2);
		t_reset(1'h1);
		t_write(1'h1, 16'hA50B, 32'h3C69_F0D4);
		t_read(1'h1, 16'h1234, 32'h8E71_4B2F);
		summarize();
	end

	// Watchdog, well beyond the 120 cycles the run needs
	initial begin
		repeat (2000) @(posedge ref_clk);
		errors++;
		summarize();
	end
endmodule
